// file: hw/lsfm_top.sv
// led string fault manager: channel classification, protections, flag
// assumes analog comparators arrive as asynchronous levels on pins
//
// Contract
// - latched open-drain low flag on any fault
// - flag clears only by reset, undervoltage or enable-off shutdown
// - suppress channel fault-outs during transients
// - input overcurrent turns all channels off
// - short comparator disables its channel
// - channel reaching target current marked good
// - good channel falling below target is open
// - overvoltage or low otp opens ungood channels
// - open channel disabled after its time-out
// - shorter open time-out when hot
// - regulated high-voltage string stays enabled
// - regulation confined to 60-100% of trip
// - undervoltage stops switching and resets state
// - current limit ends the switching cycle
// - inject current; start after switch node ok
// - sense rise then fall drops protect fet
// - enable low over 30us shuts down
// - hot open time-out is 800 us
// - normal open time-out is six periods
//
// The placing of the registers and the AXI4-Lite register port were left to the implementer.
`include "lsfm_params.svh"
`timescale 1ns/1ps
module lsfm_top
  import lsfm_pkg::*;
#(
  parameter int HOT_TMO_CYC = `LSFM_HOT_TMO_CYC,
  parameter int SETTLE_CYC = `LSFM_SETTLE_CYC
)(
  // clocking
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // analog comparator and pin levels, asynchronous
  input wire logic en_i,
  input wire logic undervoltage_lockout_i,
  input wire logic ovp_trip_i,
  input wire logic otp_low_i,
  input wire logic otp_high_i,
  input wire logic sw_ilim_i,
  input wire logic in_overcur_i,
  input wire logic switch_node_ok_i,
  input wire logic overvoltage_sense_20_i,
  input wire logic vout_below_min_i,
  input wire logic boost_pwm_i,
  input wire logic boost_cycle_i,
  input wire logic dim_period_i,
  input wire logic transient_i,
  input wire logic [`LSFM_NCH-1:0] short_channel_protect_i,
  input wire logic [`LSFM_NCH-1:0] chan_in_reg_i,
  // fault flag open-drain pin
  input wire logic fault_flag_in_i,
  output logic fault_flag_out_o,
  output logic fault_flag_oe_o,
  // power stage controls
  output logic [`LSFM_NCH-1:0] led_channel_n_en_o,
  output logic switch_gate_o,
  output logic switch_node_inject_o,
  output logic protect_fet_on_o,
  output logic vout_raise_o,
  // axi4-lite write
  input wire logic [`LSFM_AW-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [`LSFM_DW-1:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // axi4-lite read
  input wire logic [`LSFM_AW-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [`LSFM_DW-1:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i
);
  localparam int TW = $clog2(HOT_TMO_CYC + 1);
  localparam int SW = $clog2(SETTLE_CYC + 1);
  localparam int EW = $clog2(`LSFM_EN_OFF_CYC + 1);
  localparam int NCH = `LSFM_NCH;

  ////////////////////////////////////////
  // synchronisers: every level pin passes two flops first
  lsfm_sync_if #(.W(`LSFM_SI_W)) sbus ();
  logic [`LSFM_SI_W-1:0] s; // synchronised levels

  assign sbus.raw[`LSFM_SI_EN] = en_i;
  assign sbus.raw[`LSFM_SI_UNDERVOLTAGE_LOCKOUT] = undervoltage_lockout_i;
  assign sbus.raw[`LSFM_SI_OVP] = ovp_trip_i;
  assign sbus.raw[`LSFM_SI_OTPLO] = otp_low_i;
  assign sbus.raw[`LSFM_SI_OTPHI] = otp_high_i;
  assign sbus.raw[`LSFM_SI_ILIM] = sw_ilim_i;
  assign sbus.raw[`LSFM_SI_INOC] = in_overcur_i;
  assign sbus.raw[`LSFM_SI_SWOK] = switch_node_ok_i;
  assign sbus.raw[`LSFM_SI_OVS20] = overvoltage_sense_20_i;
  assign sbus.raw[`LSFM_SI_V60] = vout_below_min_i;
  assign sbus.raw[`LSFM_SI_PWM] = boost_pwm_i;
  assign sbus.raw[`LSFM_SI_CYC] = boost_cycle_i;
  assign sbus.raw[`LSFM_SI_DIM] = dim_period_i;
  assign sbus.raw[`LSFM_SI_TRANS] = transient_i;
  assign sbus.raw[`LSFM_SI_FLAG] = fault_flag_in_i;
  assign sbus.raw[`LSFM_SI_INREG-1:`LSFM_SI_SHORT] = short_channel_protect_i;
  assign sbus.raw[`LSFM_SI_W-1:`LSFM_SI_INREG] = chan_in_reg_i;
  assign s = sbus.sync;

  lsfm_sync #(.W(`LSFM_SI_W)) u_sync (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .sio(sbus)
  );

  ////////////////////////////////////////
  // enable watchdog: long low enable shuts the device down
  logic [EW-1:0] en_lo_cnt; // cycles enable has been low
  logic shut;               // shutdown latched until enable returns

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      en_lo_cnt <= '0;
      shut <= 1'b0;
    end
    else if (ce_i)
    begin
      if (s[`LSFM_SI_EN])
      begin
        en_lo_cnt <= '0;
        shut <= 1'b0;
      end
      else if (en_lo_cnt == EW'(`LSFM_EN_OFF_CYC))
        shut <= 1'b1;
      else
        en_lo_cnt <= en_lo_cnt + 1'b1;
    end
  end

  // core reset: pin reset, undervoltage or shutdown; bus logic and ctrl_mask take pin reset only
  logic rst_all;
  assign rst_all = rst_i | s[`LSFM_SI_UNDERVOLTAGE_LOCKOUT] | shut;

  ////////////////////////////////////////
  // start-up sequence and latched protections
  lsfm_seq_t seq;      // inject until switch node is up
  logic ovs_armed;     // sense has been above 20 %
  logic fet_off;       // output short: protect fet dropped
  logic inoc_lat;      // input overcurrent seen
  logic running;

  always_ff @(posedge mclk_i)
  begin
    if (rst_all)
      seq <= SEQ_INJECT;
    else if (ce_i)
    begin
      case (seq)
        SEQ_INJECT:
          if (s[`LSFM_SI_SWOK])
            seq <= SEQ_RUN;
        default:
          seq <= SEQ_RUN;
      endcase
    end
  end

  // sense rise then fall: output collapsed
  always_ff @(posedge mclk_i)
  begin
    if (rst_all)
    begin
      ovs_armed <= 1'b0;
      fet_off <= 1'b0;
      inoc_lat <= 1'b0;
    end
    else if (ce_i)
    begin
      if (s[`LSFM_SI_OVS20])
        ovs_armed <= 1'b1;
      else if (ovs_armed)
        fet_off <= 1'b1;
      if (s[`LSFM_SI_INOC])
        inoc_lat <= 1'b1;
    end
  end

  assign running = (seq == SEQ_RUN) & ~fet_off & ~inoc_lat;

  ////////////////////////////////////////
  // cycle-by-cycle current limit and boost gate
  logic cyc_d;   // previous cycle level for edge detect
  logic cyc_lim; // limit hit in this cycle

  // set wins over the new-cycle clear so a late trip is not lost
  always_ff @(posedge mclk_i)
  begin
    if (rst_all)
    begin
      cyc_d <= 1'b0;
      cyc_lim <= 1'b0;
    end
    else if (ce_i)
    begin
      cyc_d <= s[`LSFM_SI_CYC];
      if (s[`LSFM_SI_ILIM])
        cyc_lim <= 1'b1;
      else if (s[`LSFM_SI_CYC] & ~cyc_d)
        cyc_lim <= 1'b0;
    end
  end

  // gate, inject and regulation window outputs, all registered
  always_ff @(posedge mclk_i)
  begin
    if (rst_all)
    begin
      switch_gate_o <= 1'b0;
      switch_node_inject_o <= 1'b0;
      vout_raise_o <= 1'b0;
    end
    else if (ce_i)
    begin
      switch_gate_o <= running & s[`LSFM_SI_PWM] & ~cyc_lim
        & ~s[`LSFM_SI_OVP] & ~s[`LSFM_SI_OTPHI];
      switch_node_inject_o <= (seq == SEQ_INJECT);
      vout_raise_o <= running & s[`LSFM_SI_V60];
    end
  end

  // protect fet on unless reset, dropped or input overcurrent seen
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      protect_fet_on_o <= 1'b0;
    else if (ce_i)
      protect_fet_on_o <= ~rst_all & ~fet_off & ~inoc_lat;
  end

  ////////////////////////////////////////
  // stability window: transients hold off open classification
  logic [SW-1:0] settle; // cycles left until stable
  logic stable;
  logic dim_d;           // previous dimming period level
  logic dim_edge;

  always_ff @(posedge mclk_i)
  begin
    if (rst_all)
    begin
      settle <= SW'(SETTLE_CYC);
      dim_d <= 1'b0;
    end
    else if (ce_i)
    begin
      dim_d <= s[`LSFM_SI_DIM];
      if (s[`LSFM_SI_TRANS] | ~running)
        settle <= SW'(SETTLE_CYC);
      else if (settle != '0)
        settle <= settle - 1'b1;
    end
  end

  assign stable = (settle == '0);
  assign dim_edge = s[`LSFM_SI_DIM] & ~dim_d;

  ////////////////////////////////////////
  // per-channel classification and time-out
  lsfm_ch_t ch_st [NCH];
  logic [NCH-1:0] ev_short; // channel shut by short this cycle
  logic [NCH-1:0] ev_open;  // channel newly classified open
  localparam int CTRL_W = NCH;
  logic [CTRL_W-1:0] ctrl_mask;

  genvar c;
  generate
    for (c = 0; c < NCH; c++)
    begin : g_ch
      logic [TW-1:0] tmo; // cycles when hot, periods when not
      logic sh;
      logic rg;
      assign sh = s[`LSFM_SI_SHORT + c];
      assign rg = s[`LSFM_SI_INREG + c];
      assign ev_short[c] = (ch_st[c] != CH_OFF) & sh;
      assign ev_open[c] = (ch_st[c] == CH_WAIT) & ~sh & ~rg
        & (s[`LSFM_SI_OVP] | s[`LSFM_SI_OTPLO])
        | (ch_st[c] == CH_GOOD) & ~sh & ~rg & stable;

      // a regulated string is never opened by voltage alone
      always_ff @(posedge mclk_i)
      begin
        if (rst_all)
        begin
          ch_st[c] <= CH_WAIT;
          tmo <= '0;
        end
        else if (ce_i)
        begin
          case (ch_st[c])
            CH_WAIT:
              if (sh)
                ch_st[c] <= CH_OFF;
              else if (rg)
                ch_st[c] <= CH_GOOD;
              else if (s[`LSFM_SI_OVP] | s[`LSFM_SI_OTPLO])
                ch_st[c] <= CH_OPEN;
            CH_GOOD:
              if (sh)
                ch_st[c] <= CH_OFF;
              else if (~rg & stable)
                ch_st[c] <= CH_OPEN;
            CH_OPEN:
              if (sh)
                ch_st[c] <= CH_OFF;
              else if (s[`LSFM_SI_OTPLO])
              begin
                if (tmo >= TW'(HOT_TMO_CYC - 1))
                  ch_st[c] <= CH_OFF;
                else
                  tmo <= tmo + 1'b1;
              end
              else if (dim_edge)
              begin
                if (tmo >= TW'(`LSFM_OPEN_PERIODS - 1))
                  ch_st[c] <= CH_OFF;
                else
                  tmo <= tmo + 1'b1;
              end
            default:
              ch_st[c] <= CH_OFF;
          endcase
        end
      end

      // channel drive: off while sequencing, hot or overcurrent
      always_ff @(posedge mclk_i)
      begin
        if (rst_all)
          led_channel_n_en_o[c] <= 1'b0;
        else if (ce_i)
          led_channel_n_en_o[c] <= running & ctrl_mask[c]
            & ~s[`LSFM_SI_OTPHI] & (ch_st[c] != CH_OFF);
      end
    end
  endgenerate

  ////////////////////////////////////////
  // sticky fault sources and the latched flag
  logic [`LSFM_SRC_W-1:0] src; // sticky, no software clear

  always_ff @(posedge mclk_i)
  begin
    if (rst_all)
    begin
      src <= '0;
      fault_flag_oe_o <= 1'b0;
      fault_flag_out_o <= 1'b0;
    end
    else if (ce_i)
    begin
      src[`LSFM_SRC_SHORT] <= src[`LSFM_SRC_SHORT] | (|ev_short);
      src[`LSFM_SRC_OPEN] <= src[`LSFM_SRC_OPEN] | (|ev_open);
      src[`LSFM_SRC_OVP] <= src[`LSFM_SRC_OVP] | s[`LSFM_SI_OVP];
      src[`LSFM_SRC_OTP] <= src[`LSFM_SRC_OTP] | s[`LSFM_SI_OTPLO]
        | s[`LSFM_SI_OTPHI];
      src[`LSFM_SRC_INOC] <= src[`LSFM_SRC_INOC] | inoc_lat;
      src[`LSFM_SRC_OUTSH] <= src[`LSFM_SRC_OUTSH] | fet_off;
      fault_flag_oe_o <= fault_flag_oe_o | (|src);
      fault_flag_out_o <= 1'b0; // open drain only ever pulls low
    end
  end

  ////////////////////////////////////////
  // axi4-lite write: address and data in any order
  logic aw_got;                 // address held
  logic w_got;                  // data held
  logic [`LSFM_AW-1:0] aw_addr;
  logic [`LSFM_DW-1:0] w_data;
  logic [3:0] w_strb;

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= '0;
      w_data <= `LSFM_ZERO32;
      w_strb <= '0;
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o <= 1'b1;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= `LSFM_RESP_OKAY;
      ctrl_mask <= `LSFM_CTRL_RST;
    end
    else if (ce_i)
    begin
      if (s_axi_awvalid_i & s_axi_awready_o)
      begin
        aw_got <= 1'b1;
        aw_addr <= s_axi_awaddr_i;
        s_axi_awready_o <= 1'b0;
      end
      if (s_axi_wvalid_i & s_axi_wready_o)
      begin
        w_got <= 1'b1;
        w_data <= s_axi_wdata_i;
        w_strb <= s_axi_wstrb_i;
        s_axi_wready_o <= 1'b0;
      end
      if (aw_got & w_got & ~s_axi_bvalid_o)
      begin
        s_axi_bvalid_o <= 1'b1;
        if (aw_addr == `LSFM_OFF_CTRL)
        begin
          s_axi_bresp_o <= `LSFM_RESP_OKAY;
          if (w_strb[0])
            ctrl_mask <= w_data[CTRL_W-1:0];
        end
        else if (aw_addr == `LSFM_OFF_STATUS || aw_addr == `LSFM_OFF_SRC)
          s_axi_bresp_o <= `LSFM_RESP_OKAY; // read-only, write ignored
        else
          s_axi_bresp_o <= `LSFM_RESP_SLVERR;
      end
      if (s_axi_bvalid_o & s_axi_bready_i)
      begin
        s_axi_bvalid_o <= 1'b0;
        aw_got <= 1'b0;
        w_got <= 1'b0;
        s_axi_awready_o <= 1'b1;
        s_axi_wready_o <= 1'b1;
      end
    end
  end

  // read: one in flight, data taken at address beat
  logic [NCH-1:0] good_v;
  logic [NCH-1:0] open_v;
  logic [NCH-1:0] off_v;
  logic [`LSFM_DW-1:0] status_w;

  always_comb
  begin
    for (int i = 0; i < NCH; i++)
    begin
      good_v[i] = (ch_st[i] == CH_GOOD);
      open_v[i] = (ch_st[i] == CH_OPEN);
      off_v[i] = (ch_st[i] == CH_OFF);
    end
    status_w = `LSFM_ZERO32;
    status_w[`LSFM_ST_GOOD +: NCH] = good_v;
    status_w[`LSFM_ST_OPEN +: NCH] = open_v;
    status_w[`LSFM_ST_OFF +: NCH] = off_v;
    status_w[`LSFM_ST_FLAG] = fault_flag_oe_o;
    status_w[`LSFM_ST_RUN] = running;
    status_w[`LSFM_ST_FETOFF] = fet_off;
    status_w[`LSFM_ST_PIN] = s[`LSFM_SI_FLAG];
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= `LSFM_ZERO32;
      s_axi_rresp_o <= `LSFM_RESP_OKAY;
    end
    else if (ce_i)
    begin
      if (s_axi_arvalid_i & s_axi_arready_o)
      begin
        s_axi_arready_o <= 1'b0;
        s_axi_rvalid_o <= 1'b1;
        s_axi_rresp_o <= `LSFM_RESP_OKAY;
        if (s_axi_araddr_i == `LSFM_OFF_CTRL)
          s_axi_rdata_o <= {{(`LSFM_DW-CTRL_W){1'b0}}, ctrl_mask};
        else if (s_axi_araddr_i == `LSFM_OFF_STATUS)
          s_axi_rdata_o <= status_w;
        else if (s_axi_araddr_i == `LSFM_OFF_SRC)
          s_axi_rdata_o <= {{(`LSFM_DW-`LSFM_SRC_W){1'b0}}, src};
        else
        begin
          s_axi_rdata_o <= `LSFM_ZERO32;
          s_axi_rresp_o <= `LSFM_RESP_SLVERR;
        end
      end
      else if (s_axi_rvalid_o & s_axi_rready_i)
      begin
        s_axi_rvalid_o <= 1'b0;
        s_axi_arready_o <= 1'b1;
      end
    end
  end
endmodule

// file: hw/lsfm_params.svh
// fault manager constants: offsets, fields, timing
// assumes a 25 MHz control clock and an axi4-lite bus with 32-bit data
`ifndef LSFM_PARAMS_SVH
`define LSFM_PARAMS_SVH

// channel count and bus shape
`define LSFM_NCH 6
`define LSFM_AW 4
`define LSFM_DW 32

// register byte offsets
`define LSFM_OFF_CTRL 4'h0
`define LSFM_OFF_STATUS 4'h4
`define LSFM_OFF_SRC 4'h8

// reset values
`define LSFM_CTRL_RST 6'h3F
`define LSFM_ZERO32 32'h0000_0000

// status field positions
`define LSFM_ST_GOOD 0
`define LSFM_ST_OPEN 8
`define LSFM_ST_OFF 16
`define LSFM_ST_FLAG 24
`define LSFM_ST_RUN 25
`define LSFM_ST_FETOFF 26
`define LSFM_ST_PIN 27

// sticky fault source bits
`define LSFM_SRC_SHORT 0
`define LSFM_SRC_OPEN 1
`define LSFM_SRC_OVP 2
`define LSFM_SRC_OTP 3
`define LSFM_SRC_INOC 4
`define LSFM_SRC_OUTSH 5
`define LSFM_SRC_W 6

// axi responses
`define LSFM_RESP_OKAY 2'h0
`define LSFM_RESP_SLVERR 2'h2

// synchroniser bit positions
`define LSFM_SI_EN 0
`define LSFM_SI_UNDERVOLTAGE_LOCKOUT 1
`define LSFM_SI_OVP 2
`define LSFM_SI_OTPLO 3
`define LSFM_SI_OTPHI 4
`define LSFM_SI_ILIM 5
`define LSFM_SI_INOC 6
`define LSFM_SI_SWOK 7
`define LSFM_SI_OVS20 8
`define LSFM_SI_V60 9
`define LSFM_SI_PWM 10
`define LSFM_SI_CYC 11
`define LSFM_SI_DIM 12
`define LSFM_SI_TRANS 13
`define LSFM_SI_FLAG 14
`define LSFM_SI_SHORT 15
`define LSFM_SI_INREG 21
`define LSFM_SI_W 27

// timing
`define LSFM_CLK_MHZ 25
`define LSFM_EN_OFF_NS 30000
`define LSFM_EN_OFF_CYC ((`LSFM_EN_OFF_NS * `LSFM_CLK_MHZ + 999) / 1000)
`define LSFM_HOT_TMO_US 800
`define LSFM_HOT_TMO_CYC (`LSFM_HOT_TMO_US * `LSFM_CLK_MHZ)
`define LSFM_OPEN_PERIODS 6
`define LSFM_SETTLE_CYC 64

`endif

// file: hw/lsfm_pkg.sv
// types shared by the led string fault manager
// assumes lsfm_params.svh supplies all numeric constants
package lsfm_pkg;
  // per-channel classification
  typedef enum logic [1:0] {CH_WAIT, CH_GOOD, CH_OPEN, CH_OFF} lsfm_ch_t;
  // start-up sequence
  typedef enum logic {SEQ_INJECT, SEQ_RUN} lsfm_seq_t;
endpackage

// file: hw/lsfm_sync_if.sv
// carrier between the top and its synchroniser bank
// assumes both ends share mclk_i
`timescale 1ns/1ps
interface lsfm_sync_if #(
  parameter int W = 1
);
  logic [W-1:0] raw;  // asynchronous pin levels
  logic [W-1:0] sync; // levels after two flops
  modport bank (input raw, output sync);
  modport user (output raw, input sync);
endinterface

// file: hw/lsfm_sync.sv
// two-flop synchroniser bank for asynchronous comparator and pin levels
// assumes levels only; pulses shorter than one clock may be missed
`timescale 1ns/1ps
module lsfm_sync #(
  parameter int W = 1
)(
  // clocking
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // carrier
  lsfm_sync_if.bank sio
);
  logic [W-1:0] meta; // first stage, read only by the second
  logic [W-1:0] hold; // second stage

  ////////////////////////////////////////
  // one flop pair per bit
  genvar b;
  generate
    for (b = 0; b < W; b++)
    begin : g_bit
      always_ff @(posedge mclk_i)
      begin
        if (rst_i)
        begin
          meta[b] <= 1'b0;
          hold[b] <= 1'b0;
        end
        else if (ce_i)
        begin
          meta[b] <= sio.raw[b];
          hold[b] <= meta[b];
        end
      end
    end
  endgenerate

  assign sio.sync = hold;
endmodule

// file: testbench/lsfm_chk.sv
// checker for the led string fault manager, bound to its top
// assumes pins are asynchronous levels and two synchroniser flops
`include "lsfm_params.svh"
`timescale 1ns/1ps
module lsfm_chk (
  // clocking
  input logic mclk_i,
  input logic rst_i,
  // pins watched
  input logic en_i,
  input logic undervoltage_lockout_i,
  input logic in_overcur_i,
  input logic sw_ilim_i,
  input logic vout_below_min_i,
  input logic switch_node_ok_i,
  input logic overvoltage_sense_20_i,
  input logic [`LSFM_NCH-1:0] short_channel_protect_i,
  // outputs watched
  input logic fault_flag_out_o,
  input logic fault_flag_oe_o,
  input logic [`LSFM_NCH-1:0] led_channel_n_en_o,
  input logic switch_gate_o,
  input logic protect_fet_on_o,
  input logic vout_raise_o,
  // bus handshakes
  input logic s_axi_rvalid_o,
  input logic s_axi_rready_i,
  input logic [`LSFM_DW-1:0] s_axi_rdata_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////
  logic [3:0] quiet; // cycles since a legal flag clear cause
  // saturating, so a late clear with no cause is caught
  always_ff @(posedge mclk_i)
    if (rst_i || undervoltage_lockout_i || !en_i)
      quiet <= '0;
    else if (quiet != 4'hf)
      quiet <= quiet + 4'h1;
  ////////////////////////////////////////
  a_flag_drain: assert property (fault_flag_out_o == 1'b0)
    else $error("flag pin driven high");
  a_flag_sets: assert property ($rose(short_channel_protect_i[0])
    |-> ##[1:8] fault_flag_oe_o) else $error("flag not set");
  a_flag_latch: assert property ($fell(fault_flag_oe_o) |-> quiet < 4'h8)
    else $error("flag cleared without cause");
  a_overcur_off: assert property ($rose(in_overcur_i)
    |-> ##[1:6] led_channel_n_en_o == '0) else $error("channels on");
  a_short_off: assert property ($rose(short_channel_protect_i[0])
    |-> ##[1:6] !led_channel_n_en_o[0]) else $error("short ch on");
  a_raise_cause: assert property (vout_raise_o |-> $past(vout_below_min_i, 3)
    || $past(vout_below_min_i, 4) || $past(vout_below_min_i, 5))
    else $error("raise without low output");
  a_undervoltage_lockout_stop: assert property (undervoltage_lockout_i [*6] |-> !switch_gate_o
    && led_channel_n_en_o == '0 && !fault_flag_oe_o)
    else $error("running in lockout");
  a_ilim_gate: assert property (sw_ilim_i [*6] |-> !switch_gate_o)
    else $error("gate on over limit");
  a_gate_start: assert property ($rose(switch_gate_o)
    |-> $past(switch_node_ok_i, 3)) else $error("early start");
  a_fet_drop: assert property ($fell(overvoltage_sense_20_i)
    |-> ##[1:6] !protect_fet_on_o) else $error("fet still on");
  a_sync_lag: assert property ($rose(in_overcur_i) && led_channel_n_en_o != '0
    |=> led_channel_n_en_o != '0) else $error("no sync lag");
  a_rvalid_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i
    |=> s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("r dropped");
  // main scenarios reached
  c_open_off: cover property ($fell(led_channel_n_en_o[1]));
  c_fet_off: cover property ($fell(protect_fet_on_o));
  c_flag_on: cover property ($rose(fault_flag_oe_o));
endmodule

// file: testbench/lsfm_partner.sv
// far-side model: led strings, boost stage and dimming timebase
// assumes the bench picks which strings fail open
`timescale 1ns/1ps
module lsfm_partner (
  // clocking
  input logic mclk_i,
  input logic rst_i,
  // from the block
  input logic [5:0] en_i,
  input logic inject_i,
  // commanded failures
  input logic [5:0] open_i,
  // to the block
  output logic [5:0] in_reg_o,
  output logic node_ok_o,
  output logic dim_o,
  output logic cyc_o,
  output logic pwm_o
);
  logic [4:0] tick; // free divider for cycle and dim period
  logic [3:0] chg; // switch node charge, kept across shutdown
  ////////////////////////////////////////
  // a string regulates one cycle after enable, never while off
  always_ff @(posedge mclk_i)
    in_reg_o <= en_i & ~open_i;
  // reset so the timebase never stays unknown
  always_ff @(posedge mclk_i)
    if (rst_i)
      tick <= '0;
    else
      tick <= tick + 5'h01;
  // switch node only passes after injected charge builds up
  always_ff @(posedge mclk_i)
    if (rst_i)
      chg <= '0;
    else if (inject_i && chg != 4'hf)
      chg <= chg + 4'h1;
  assign node_ok_o = chg > 4'h7;
  assign dim_o = tick[4]; // 32-cycle dimming period
  assign cyc_o = tick[1];
  assign pwm_o = tick[2];
endmodule

// file: testbench/lsfm_top_tb.sv
// bench for the fault manager: bus tasks and scenarios
// assumes the far-side model and checker
`include "lsfm_params.svh"
`timescale 1ns/1ps
`define CK(n,e,g) begin compares++; if ((g) !== (e)) begin bad_count++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
module lsfm_top_tb
  import lsfm_pkg::*;
;
  logic mclk_i = 0, rst_i = 1, ce_i = 1, en_i = 1;
  logic undervoltage_lockout_i = 0, ovp_trip_i = 0, otp_low_i = 0;
  logic otp_high_i = 0, sw_ilim_i = 0, in_overcur_i = 0;
  logic overvoltage_sense_20_i = 0, vout_below_min_i = 0, transient_i = 0;
  logic switch_node_ok_i, boost_pwm_i, boost_cycle_i, dim_period_i;
  logic [5:0] short_channel_protect_i = 0, chan_in_reg_i, open_m = 0;
  logic fault_flag_in_i, fault_flag_out_o, fault_flag_oe_o;
  logic [5:0] led_channel_n_en_o;
  logic switch_gate_o, switch_node_inject_o, protect_fet_on_o, vout_raise_o;
  logic [3:0] s_axi_awaddr_i = 0, s_axi_araddr_i = 0, s_axi_wstrb_i = 4'hf;
  logic [31:0] s_axi_wdata_i = 0, s_axi_rdata_o, rdat;
  logic s_axi_awvalid_i = 0, s_axi_wvalid_i = 0, s_axi_arvalid_i = 0;
  logic s_axi_bready_i = 1, s_axi_rready_i = 1;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
  logic s_axi_arready_o, s_axi_rvalid_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o, rrsp;
  int bad_count = 0, compares = 0, cyc_n = 0;
  // pulled-up flag wire
  assign fault_flag_in_i = fault_flag_oe_o ? fault_flag_out_o : 1'b1;
  lsfm_top #(.HOT_TMO_CYC(20), .SETTLE_CYC(4)) i_lsfm_top (.*);
  lsfm_partner i_lsfm_partner (.mclk_i(mclk_i), .rst_i(rst_i),
    .en_i(led_channel_n_en_o), .inject_i(switch_node_inject_o),
    .open_i(open_m), .in_reg_o(chan_in_reg_i), .node_ok_o(switch_node_ok_i),
    .dim_o(dim_period_i), .cyc_o(boost_cycle_i), .pwm_o(boost_pwm_i));
  ////////////////////////////////////////
  initial
    forever #20 mclk_i = ~mclk_i;
  // hang guard
  always @(posedge mclk_i)
  begin
    cyc_n++;
    if (cyc_n == 12000)
    begin
      bad_count++;
      summarize;
    end
  end
  task summarize;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task run(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  // write: each valid dropped when taken
  task wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] e);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    do
    begin
      @(posedge mclk_i);
      if (s_axi_awready_o === 1'b1)
        s_axi_awvalid_i <= 1'b0;
      if (s_axi_wready_o === 1'b1)
        s_axi_wvalid_i <= 1'b0;
    end while (s_axi_bvalid_o !== 1'b1);
    `CK("bresp", e, s_axi_bresp_o)
  endtask
  task rd(input logic [3:0] a);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    do
    begin
      @(posedge mclk_i);
      if (s_axi_arready_o === 1'b1)
        s_axi_arvalid_i <= 1'b0;
    end while (s_axi_rvalid_o !== 1'b1);
    rdat = s_axi_rdata_o;
    rrsp = s_axi_rresp_o;
  endtask
  // poll until running
  task wait_run;
    for (int i = 0; i < 60; i++)
    begin
      rd(`LSFM_OFF_STATUS);
      if (rdat[`LSFM_ST_RUN] === 1'b1)
        break;
      run(4);
    end
    `CK("running", 1'b1, rdat[`LSFM_ST_RUN])
  endtask
  ////////////////////////////////////////
  initial
  begin
    run(8);
    rst_i <= 1'b0;
    rd(`LSFM_OFF_CTRL);
    `CK("ctrl", 32'h0000_003f, rdat)
    rd(4'hc);
    `CK("rresp", `LSFM_RESP_SLVERR, rrsp)
    wr(4'hc, '0, `LSFM_RESP_SLVERR);
    wait_run;
    run(20);
    rd(`LSFM_OFF_STATUS);
    `CK("good", 6'h3f, rdat[5:0])
    // transient masks a current dip
    transient_i <= 1'b1;
    open_m[2] <= 1'b1;
    run(400);
    `CK("ch2", 1'b1, led_channel_n_en_o[2])
    open_m[2] <= 1'b0;
    run(2);
    transient_i <= 1'b0;
    run(20);
    // open string, normal temperature
    open_m[1] <= 1'b1;
    run(100);
    `CK("ch1", 1'b1, led_channel_n_en_o[1])
    run(200);
    `CK("ch1", 1'b0, led_channel_n_en_o[1])
    `CK("flag", 1'b1, fault_flag_oe_o)
    open_m[1] <= 1'b0;
    run(50);
    `CK("ch1", 1'b0, led_channel_n_en_o[1])
    short_channel_protect_i[0] <= 1'b1;
    run(10);
    short_channel_protect_i[0] <= 1'b0;
    run(20);
    `CK("ch0", 1'b0, led_channel_n_en_o[0])
    rd(`LSFM_OFF_SRC);
    `CK("src", 1'b1, rdat[`LSFM_SRC_SHORT])
    // hot: short time-out
    otp_low_i <= 1'b1;
    open_m[3] <= 1'b1;
    run(12);
    `CK("ch3", 1'b1, led_channel_n_en_o[3])
    run(30);
    `CK("ch3", 1'b0, led_channel_n_en_o[3])
    otp_low_i <= 1'b0;
    open_m[3] <= 1'b0;
    sw_ilim_i <= 1'b1;
    run(8);
    `CK("gate", 1'b0, switch_gate_o)
    sw_ilim_i <= 1'b0;
    vout_below_min_i <= 1'b1;
    run(8);
    `CK("raise", 1'b1, vout_raise_o)
    vout_below_min_i <= 1'b0;
    run(8);
    `CK("raise", 1'b0, vout_raise_o)
    // short enable dip, then long
    en_i <= 1'b0;
    run(100);
    en_i <= 1'b1;
    run(10);
    `CK("flag", 1'b1, fault_flag_oe_o)
    en_i <= 1'b0;
    open_m <= 6'h10;
    run(800);
    `CK("flag", 1'b0, fault_flag_oe_o)
    `CK("leds", 6'h00, led_channel_n_en_o)
    en_i <= 1'b1;
    wait_run;
    run(400);
    `CK("ch4", 1'b1, led_channel_n_en_o[4])
    ovp_trip_i <= 1'b1;
    run(10);
    ovp_trip_i <= 1'b0;
    run(300);
    `CK("ch4", 1'b0, led_channel_n_en_o[4])
    `CK("ch5", 1'b1, led_channel_n_en_o[5])
    overvoltage_sense_20_i <= 1'b1;
    run(10);
    overvoltage_sense_20_i <= 1'b0;
    run(10);
    `CK("fet", 1'b0, protect_fet_on_o)
    in_overcur_i <= 1'b1;
    run(8);
    `CK("leds", 6'h00, led_channel_n_en_o)
    in_overcur_i <= 1'b0;
    undervoltage_lockout_i <= 1'b1;
    open_m <= '0;
    run(8);
    `CK("gate", 1'b0, switch_gate_o)
    `CK("flag", 1'b0, fault_flag_oe_o)
    undervoltage_lockout_i <= 1'b0;
    wait_run;
    wr(`LSFM_OFF_CTRL, 32'h0000_001f, `LSFM_RESP_OKAY);
    run(30);
    `CK("masked", 6'h1f, led_channel_n_en_o)
    summarize;
  end
endmodule
bind lsfm_top lsfm_chk i_lsfm_chk (.*);
